// ===== rtl/cls_slice.sv
// Configurable logic slice: logic, ripple, RAM and ROM modes
//
// Operation
// - Slice offers logic, ripple arithmetic, distributed RAM and ROM modes.
// - Reduced variant has logic, ripple and ROM, but no RAM.
// - Logic mode: each table is a programmed sixteen-entry four-input function.
// - Slice gives two four-input functions or one five-input function.
// - Six to eight inputs come from concatenating outputs of several slices.
// - Ripple mode adds, subtracts, or does either chosen by a dynamic input.
// - Ripple mode also counts up or down over two bits.
// - Ripple mode serves as a multiplier building block.
// - Ripple mode compares A and B: greater-equal, not-equal, less-equal.
// - Fast-carry option outputs carry generate and propagate for chaining.
// - RAM mode: each table is a sixteen-by-one memory.
// - Single-port 16x2 RAM uses one slice; dual-port uses two slices.
// - Dual-port pair: one slice read-write, companion read-only, same data.
`timescale 1ns/10ps
`include "cls_slice_cfg.svh"

module cls_slice
  import cls_slice_pkg::*;
#(
  // 1: full function unit, 0: reduced function unit without RAM
  parameter bit FULL_FUNCTION = 1'b1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Configuration, held static in use except for table loads
  input wire cls_mode_type cfg_mode,
  input wire cls_op_type cfg_op,
  input wire cls_cmp_type cfg_cmp,
  input wire cls_ram_role_type cfg_ram_role,
  input wire logic cfg_five_input,
  input wire logic cfg_fast_carry,
  input wire logic cfg_load,
  input wire logic cfg_load_sel,
  input wire logic [`CLS_TABLE_DEPTH-1:0] cfg_contents,
  // Table inputs from routing
  input wire logic [`CLS_ADDR_W-1:0] tbl0_in,
  input wire logic [`CLS_ADDR_W-1:0] tbl1_in,
  input wire logic fifth_in,
  // Concatenation from neighbouring slices
  input wire logic cat_lo_in,
  input wire logic cat_hi_in,
  input wire logic cat_sel,
  // Ripple operands
  input wire logic [`CLS_ARITH_W-1:0] opa,
  input wire logic [`CLS_ARITH_W-1:0] opb,
  input wire logic carry_in,
  input wire logic add_not_sub,
  input wire logic mult_bit,
  // Read-write memory port
  input wire logic ram_wr_en,
  input wire logic [`CLS_ARITH_W-1:0] ram_wr_data,
  // Write bus from the read-write companion slice
  input wire logic nb_wr_en,
  input wire logic [`CLS_ADDR_W-1:0] nb_wr_addr,
  input wire logic [`CLS_ARITH_W-1:0] nb_wr_data,
  // Combinational results for chaining
  output logic func0,
  output logic func1,
  output logic func5,
  output logic cat_out,
  output logic carry_out,
  output logic carry_gen,
  output logic carry_prop,
  output logic [`CLS_ARITH_W-1:0] ram_rd_data,
  // Write bus offered to a read-only companion slice
  output logic wr_bus_en,
  output logic [`CLS_ADDR_W-1:0] wr_bus_addr,
  output logic [`CLS_ARITH_W-1:0] wr_bus_data,
  // Registered results
  output logic [`CLS_ARITH_W-1:0] result_q,
  output logic carry_q,
  output logic cmp_q,
  output logic mode_err_q
);

  // Returns true for the counting functions, which use the counter
  function automatic logic is_counter(input cls_op_type op);
    is_counter = (op == CLS_OP_UP) || (op == CLS_OP_DOWN);
  endfunction

  // Returns true when the slice really runs as distributed RAM.
  // A reduced unit asked for memory keeps its tables read-only, so a
  // stray configuration can never corrupt programmed logic contents.
  function automatic logic ram_active(input cls_mode_type mode);
    ram_active = FULL_FUNCTION && (mode == CLS_MODE_RAM);
  endfunction

  // Returns true in ripple mode, which gates every arithmetic output
  function automatic logic is_ripple(input cls_mode_type mode);
    is_ripple = (mode == CLS_MODE_RIPPLE);
  endfunction

  // Table plumbing
  logic [`CLS_TABLES-1:0] tbl_out;
  logic [`CLS_TABLES-1:0] tbl_wr_en;
  logic [`CLS_TABLES-1:0] tbl_wr_data;
  logic [`CLS_ADDR_W-1:0] tbl_wr_addr;
  logic [`CLS_ADDR_W-1:0] tbl_rd_addr [`CLS_TABLES];

  // Counter state and arithmetic core results
  logic [`CLS_ARITH_W-1:0] count_q;
  logic [`CLS_ARITH_W-1:0] arith_a;
  logic [`CLS_ARITH_W-1:0] arith_sum;
  logic arith_cout;
  logic arith_gen;
  logic arith_prop;
  logic a_ge_b;
  logic a_ne_b;
  logic a_le_b;
  logic cmp_sel;

  // Mode decodes and the selected logic function
  logic in_ram;
  logic logic_out;

  // Memory mode only where the unit really has it
  assign in_ram = ram_active(cfg_mode);

  // Write source: own port, or the companion's bus in read-only role.
  // Outside memory mode nothing writes, so logic contents stay intact.
  always_comb begin
    tbl_wr_addr = tbl0_in;
    tbl_wr_en = '0;
    tbl_wr_data = ram_wr_data;
    if (in_ram) begin
      unique case (cfg_ram_role)
        CLS_RAM_RO_PORT: begin
          // Read-only half mirrors every write of its partner
          tbl_wr_addr = nb_wr_addr;
          tbl_wr_en = {`CLS_TABLES{nb_wr_en}};
          tbl_wr_data = nb_wr_data;
        end
        CLS_RAM_SINGLE,
        CLS_RAM_RW_PORT: begin
          tbl_wr_en = {`CLS_TABLES{ram_wr_en}};
        end
        default: begin
          // Unused role code writes nothing
          tbl_wr_en = '0;
        end
      endcase
    end
  end

  // Two tables; in RAM mode they share one address for 16x2,
  // so one address picks both bits of a two-bit word
  generate
    for (genvar t = 0; t < `CLS_TABLES; t++) begin : g_table
      // First table always reads its own address
      if (t == 0) begin : g_addr0
        assign tbl_rd_addr[t] = tbl0_in;
      end else begin : g_addrn
        assign tbl_rd_addr[t] = in_ram ? tbl0_in : tbl1_in;
      end
      cls_table16 u_table (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .load_en(cfg_load && (cfg_load_sel == 1'(t))),
        .load_data(cfg_contents),
        .wr_en(tbl_wr_en[t]),
        .wr_addr(tbl_wr_addr),
        .wr_data(tbl_wr_data[t]),
        .rd_addr(tbl_rd_addr[t]),
        .rd_data(tbl_out[t])
      );
    end
  endgenerate

  // Logic and ROM both read the programmed tables
  assign func0 = tbl_out[0];
  assign func1 = tbl_out[1];
  // Fifth input picks between the two tables
  assign func5 = fifth_in ? tbl_out[1] : tbl_out[0];
  // Wider functions mux two neighbour outputs; chain for seven and eight
  assign cat_out = cat_sel ? cat_hi_in : cat_lo_in;
  // Registered logic result may use the five-input form
  assign logic_out = cfg_five_input ? func5 : func0;

  // Memory read data for either port role; zero in other modes so
  // a neighbour reading it sees no programmed logic contents
  assign ram_rd_data = in_ram ? tbl_out : '0;

  // Exported write bus only in read-write role
  // Address and data always shown; only the enable is qualified
  assign wr_bus_en = in_ram && (cfg_ram_role == CLS_RAM_RW_PORT) &&
    ram_wr_en;
  assign wr_bus_addr = tbl0_in;
  assign wr_bus_data = ram_wr_data;

  // Counters feed back their own state as the first operand
  assign arith_a = is_counter(cfg_op) ? count_q : opa;

  // One shared arithmetic core; the mode decodes below decide which
  // of its outputs are allowed to leave the slice
  cls_arith2 u_arith (
    .op(cfg_op),
    .opa(arith_a),
    .opb(opb),
    .carry_in(carry_in),
    .add_not_sub(add_not_sub),
    .mult_bit(mult_bit),
    .sum(arith_sum),
    .carry_out(arith_cout),
    .carry_gen(arith_gen),
    .carry_prop(arith_prop),
    .a_ge_b(a_ge_b),
    .a_ne_b(a_ne_b),
    .a_le_b(a_le_b)
  );

  // Generate and propagate only leave the slice in fast-carry form;
  // held low otherwise so an idle slice never disturbs a carry chain
  assign carry_gen = is_ripple(cfg_mode) && cfg_fast_carry &&
    arith_gen;
  assign carry_prop = is_ripple(cfg_mode) && cfg_fast_carry &&
    arith_prop;
  assign carry_out = is_ripple(cfg_mode) && arith_cout;

  // Comparator output selection
  always_comb begin
    cmp_sel = a_ge_b;
    unique case (cfg_cmp)
      CLS_CMP_GE: cmp_sel = a_ge_b;
      CLS_CMP_NE: cmp_sel = a_ne_b;
      CLS_CMP_LE: cmp_sel = a_le_b;
      default: cmp_sel = a_ge_b;
    endcase
  end

  // Counter steps by the incoming carry, so slices chain into wide counters
  // Holds its value in every other function, ready for the next count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_q <= `CLS_COUNT_RESET;
    end else if (clk_en && is_ripple(cfg_mode) &&
                 is_counter(cfg_op)) begin
      count_q <= arith_sum;
    end
  end

  // Result register for the mode in use; one cycle behind the
  // combinational outputs, for users that want a registered slice
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      result_q <= `CLS_COUNT_RESET;
    end else if (clk_en) begin
      unique case (cfg_mode)
        CLS_MODE_LOGIC: begin
          result_q <= {func1, logic_out};
        end
        CLS_MODE_RIPPLE: begin
          result_q <= arith_sum;
        end
        CLS_MODE_RAM: begin
          // Reduced unit falls back to ROM reads here
          result_q <= tbl_out;
        end
        CLS_MODE_ROM: begin
          result_q <= tbl_out;
        end
      endcase
    end
  end

  // Registered carry, so a chained slice can pipeline its carry out;
  // zero outside ripple mode so no stale carry reaches a neighbour
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      carry_q <= 1'b0;
    end else if (clk_en) begin
      carry_q <= is_ripple(cfg_mode) && arith_cout;
    end
  end

  // Compare flag is only meaningful in ripple mode
  // Forced low elsewhere so a stale compare never leaks out
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmp_q <= 1'b0;
    end else if (clk_en) begin
      cmp_q <= is_ripple(cfg_mode) && cmp_sel;
    end
  end

  // Flags a RAM request on a unit that cannot provide one
  // Level, not sticky: it clears on the next enabled clock after the mode is changed
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_err_q <= 1'b0;
    end else if (clk_en) begin
      mode_err_q <= !FULL_FUNCTION && (cfg_mode == CLS_MODE_RAM);
    end
  end

endmodule

// ===== rtl/cls_slice_cfg.svh
// Constants for the configurable logic slice
`ifndef CLS_SLICE_CFG_SVH
`define CLS_SLICE_CFG_SVH

// Table geometry: sixteen words of one bit, four address inputs
`define CLS_TABLE_DEPTH 16
`define CLS_ADDR_W 4
// Arithmetic width of one slice
`define CLS_ARITH_W 2
// Number of tables per slice
`define CLS_TABLES 2
// Reset value of every table's contents
`define CLS_TABLE_RESET 16'h0000
// Reset value of the counter and result registers
`define CLS_COUNT_RESET 2'h0

`endif

// ===== rtl/cls_slice_pkg.sv
// Types shared by the configurable logic slice
package cls_slice_pkg;

  // Operating modes of a slice
  typedef enum logic [1:0] {
    CLS_MODE_LOGIC,
    CLS_MODE_RIPPLE,
    CLS_MODE_RAM,
    CLS_MODE_ROM
  } cls_mode_type;

  // Ripple-mode functions
  typedef enum logic [2:0] {
    CLS_OP_ADD,
    CLS_OP_SUB,
    CLS_OP_ADDSUB,
    CLS_OP_UP,
    CLS_OP_DOWN,
    CLS_OP_MULT,
    CLS_OP_CMP
  } cls_op_type;

  // Role of a slice within a distributed memory
  typedef enum logic [1:0] {
    CLS_RAM_SINGLE,
    CLS_RAM_RW_PORT,
    CLS_RAM_RO_PORT
  } cls_ram_role_type;

  // Comparator result routed to the compare output
  typedef enum logic [1:0] {
    CLS_CMP_GE,
    CLS_CMP_NE,
    CLS_CMP_LE
  } cls_cmp_type;

endpackage

// ===== rtl/cls_table16.sv
// Sixteen-by-one table used as logic, ROM or distributed RAM
`timescale 1ns/10ps
`include "cls_slice_cfg.svh"

module cls_table16 (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic load_en,
  input wire logic [`CLS_TABLE_DEPTH-1:0] load_data,
  input wire logic wr_en,
  input wire logic [`CLS_ADDR_W-1:0] wr_addr,
  input wire logic wr_data,
  input wire logic [`CLS_ADDR_W-1:0] rd_addr,
  output logic rd_data
);

  logic [`CLS_TABLE_DEPTH-1:0] bits_q;

  // Configuration load beats a user write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bits_q <= `CLS_TABLE_RESET;
    end else if (clk_en) begin
      if (load_en) begin
        bits_q <= load_data;
      end else if (wr_en) begin
        bits_q[wr_addr] <= wr_data;
      end
    end
  end

  // Read is a plain mux so the table can act as logic
  assign rd_data = bits_q[rd_addr];

endmodule

// ===== rtl/cls_arith2.sv
// Two-bit ripple arithmetic unit with carry generate and propagate
`timescale 1ns/10ps
`include "cls_slice_cfg.svh"

module cls_arith2
  import cls_slice_pkg::*;
(
  input wire cls_op_type op,
  input wire logic [`CLS_ARITH_W-1:0] opa,
  input wire logic [`CLS_ARITH_W-1:0] opb,
  input wire logic carry_in,
  input wire logic add_not_sub,
  input wire logic mult_bit,
  output logic [`CLS_ARITH_W-1:0] sum,
  output logic carry_out,
  output logic carry_gen,
  output logic carry_prop,
  output logic a_ge_b,
  output logic a_ne_b,
  output logic a_le_b
);

  logic [`CLS_ARITH_W-1:0] b_eff;
  logic cin_eff;
  logic [`CLS_ARITH_W:0] gen_sum;
  logic [`CLS_ARITH_W:0] full_sum;
  logic [`CLS_ARITH_W:0] rev_sum;

  // Second operand shaped by the selected function
  always_comb begin
    b_eff = opb;
    cin_eff = carry_in;
    unique case (op)
      CLS_OP_ADD: b_eff = opb;
      CLS_OP_SUB: b_eff = ~opb;
      CLS_OP_ADDSUB: b_eff = add_not_sub ? opb : ~opb;
      CLS_OP_UP: b_eff = 2'h0;
      CLS_OP_DOWN: b_eff = 2'h3;
      CLS_OP_MULT: b_eff = opb & {`CLS_ARITH_W{mult_bit}};
      CLS_OP_CMP: begin
        b_eff = ~opb;
        cin_eff = 1'b1;
      end
      default: b_eff = opb;
    endcase
  end

  // Generate is the carry with no carry in; propagate needs all XORs
  assign gen_sum = {1'b0, opa} + {1'b0, b_eff};
  assign carry_gen = gen_sum[`CLS_ARITH_W];
  assign carry_prop = &(opa ^ b_eff);
  assign full_sum = gen_sum + {{`CLS_ARITH_W{1'b0}}, cin_eff};
  assign sum = full_sum[`CLS_ARITH_W-1:0];
  assign carry_out = carry_gen | (carry_prop & cin_eff);

  // Comparator from the same adder, plus a reverse subtract
  assign rev_sum = {1'b0, opb} + {1'b0, ~opa} + 3'h1;
  assign a_ge_b = full_sum[`CLS_ARITH_W];
  assign a_ne_b = |(opa ^ opb);
  assign a_le_b = rev_sum[`CLS_ARITH_W];

endmodule

// ===== sim/cls_slice_chk.sv
// Port-level assertions for the configurable logic slice
`timescale 1ns/10ps
`include "cls_slice_cfg.svh"
module cls_slice_chk
  import cls_slice_pkg::*;
#(
  parameter bit FULL_FUNCTION = 1'b1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire cls_mode_type cfg_mode,
  input wire cls_op_type cfg_op,
  input wire logic cfg_five_input,
  input wire logic cfg_fast_carry,
  input wire logic [`CLS_ADDR_W-1:0] tbl0_in,
  input wire logic cat_lo_in,
  input wire logic cat_hi_in,
  input wire logic cat_sel,
  input wire logic [`CLS_ARITH_W-1:0] opa,
  input wire logic [`CLS_ARITH_W-1:0] opb,
  input wire logic carry_in,
  input wire logic ram_wr_en,
  input wire logic [`CLS_ARITH_W-1:0] ram_wr_data,
  input wire logic func0,
  input wire logic func1,
  input wire logic func5,
  input wire logic cat_out,
  input wire logic carry_out,
  input wire logic carry_gen,
  input wire logic carry_prop,
  input wire logic [`CLS_ARITH_W-1:0] ram_rd_data,
  input wire logic [`CLS_ARITH_W-1:0] result_q,
  input wire logic mode_err_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Expected next values, kept as signals so $past sees plain names
  logic [1:0] lg_d;
  logic [1:0] add_s;
  assign lg_d = {func1, cfg_five_input ? func5 : func0};
  assign add_s = opa + opb + carry_in;
  cat_mux_a: assert property (cat_out == (cat_sel ? cat_hi_in : cat_lo_in))
    else $error("cat_out does not follow its select");
  fc_gate_a: assert property (!(cfg_mode == CLS_MODE_RIPPLE && cfg_fast_carry)
    |-> !carry_gen && !carry_prop)
    else $error("carry generate or propagate outside fast carry");
  carry_rel_a: assert property (cfg_mode == CLS_MODE_RIPPLE && cfg_fast_carry
    |-> carry_out == (carry_gen | carry_prop & carry_in))
    else $error("carry out disagrees with generate and propagate");
  ram_zero_a: assert property (cfg_mode != CLS_MODE_RAM |-> ram_rd_data == 2'h0)
    else $error("memory read data outside memory mode");
  ram_wr_a: assert property (FULL_FUNCTION && cfg_mode == CLS_MODE_RAM &&
    clk_en && ram_wr_en ##1 cfg_mode == CLS_MODE_RAM && $stable(tbl0_in)
    |-> ram_rd_data == $past(ram_wr_data))
    else $error("written word not read back");
  logic_reg_a: assert property (cfg_mode == CLS_MODE_LOGIC && clk_en
    |=> result_q == $past(lg_d))
    else $error("registered logic result wrong");
  add_reg_a: assert property (cfg_mode == CLS_MODE_RIPPLE &&
    cfg_op == CLS_OP_ADD && clk_en |=> result_q == $past(add_s))
    else $error("registered sum wrong");
  ram_err_a: assert property (cfg_mode == CLS_MODE_RAM && clk_en
    |=> mode_err_q == !FULL_FUNCTION)
    else $error("mode error flag wrong for memory mode");
endmodule

bind cls_slice cls_slice_chk #(.FULL_FUNCTION(FULL_FUNCTION)) chk (
  .sys_clk, .sys_rst, .clk_en, .cfg_mode, .cfg_op, .cfg_five_input,
  .cfg_fast_carry, .tbl0_in, .cat_lo_in, .cat_hi_in, .cat_sel, .opa, .opb,
  .carry_in, .ram_wr_en, .ram_wr_data, .func0, .func1, .func5, .cat_out,
  .carry_out, .carry_gen, .carry_prop, .ram_rd_data, .result_q, .mode_err_q);

// ===== sim/cls_nb_model.sv
// Neighbouring slice that feeds the concatenation inputs
`timescale 1ns/10ps
`include "cls_slice_cfg.svh"
module cls_nb_model #(
  parameter logic [15:0] LO_TBL = 16'h6996,
  parameter logic [15:0] HI_TBL = 16'h8001
) (
  input wire logic [`CLS_ADDR_W-1:0] nb_addr,
  output logic cat_lo_in,
  output logic cat_hi_in
);
  // Two four-input functions of the neighbour, no register in the path
  assign cat_lo_in = LO_TBL[nb_addr];
  assign cat_hi_in = HI_TBL[nb_addr];
endmodule

// ===== sim/cls_slice_tb.sv
// Self-checking bench for the configurable logic slice
`timescale 1ns/10ps
`include "cls_slice_cfg.svh"
module cls_slice_tb;
  import cls_slice_pkg::*;
  localparam logic [15:0] P0 = 16'hA5C3;
  localparam logic [15:0] P1 = 16'h0FF0;
  localparam logic [15:0] NB_LO = 16'h6996;
  localparam logic [15:0] NB_HI = 16'h8001;
  cls_op_type ops[4] = '{CLS_OP_ADD, CLS_OP_SUB, CLS_OP_ADDSUB, CLS_OP_MULT};
  logic sys_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1;
  cls_mode_type cfg_mode = CLS_MODE_LOGIC;
  cls_op_type cfg_op = CLS_OP_ADD;
  cls_cmp_type cfg_cmp = CLS_CMP_GE;
  cls_ram_role_type cfg_ram_role = CLS_RAM_SINGLE;
  logic cfg_five_input = 1'h0, cfg_fast_carry = 1'h0, cfg_load = 1'h0;
  logic cfg_load_sel = 1'h0, fifth_in = 1'h0, cat_sel = 1'h0;
  logic carry_in = 1'h0, add_not_sub = 1'h1, mult_bit = 1'h0;
  logic ram_wr_en = 1'h0, nb_wr_en = 1'h0;
  logic [15:0] cfg_contents = 16'h0000;
  logic [3:0] tbl0_in = 4'h0, tbl1_in = 4'h0, nb_addr = 4'h0;
  logic [3:0] nb_wr_addr = 4'h0, wr_bus_addr;
  logic [1:0] opa = 2'h0, opb = 2'h0, ram_wr_data = 2'h0, nb_wr_data = 2'h0;
  logic [1:0] ram_rd_data, wr_bus_data, result_q;
  logic func0, func1, func5, cat_out, cat_lo_in, cat_hi_in, carry_out;
  logic carry_gen, carry_prop, wr_bus_en, carry_q, cmp_q, mode_err_q;
  logic [1:0] red_rd_data;
  logic red_err_q;
  int mismatches = 0, comparisons = 0, cyc = 0;

  cls_slice #(.FULL_FUNCTION(1'h1)) uut (.sys_clk, .sys_rst, .clk_en,
    .cfg_mode, .cfg_op, .cfg_cmp, .cfg_ram_role, .cfg_five_input,
    .cfg_fast_carry, .cfg_load, .cfg_load_sel, .cfg_contents, .tbl0_in,
    .tbl1_in, .fifth_in, .cat_lo_in, .cat_hi_in, .cat_sel, .opa, .opb,
    .carry_in, .add_not_sub, .mult_bit, .ram_wr_en, .ram_wr_data,
    .nb_wr_en, .nb_wr_addr, .nb_wr_data, .func0, .func1, .func5, .cat_out,
    .carry_out, .carry_gen, .carry_prop, .ram_rd_data, .wr_bus_en,
    .wr_bus_addr, .wr_bus_data, .result_q, .carry_q, .cmp_q, .mode_err_q);
  // Reduced unit on the same inputs, to show memory mode is refused
  cls_slice #(.FULL_FUNCTION(1'h0)) uut_red (.sys_clk, .sys_rst, .clk_en,
    .cfg_mode, .cfg_op, .cfg_cmp, .cfg_ram_role, .cfg_five_input,
    .cfg_fast_carry, .cfg_load, .cfg_load_sel, .cfg_contents, .tbl0_in,
    .tbl1_in, .fifth_in, .cat_lo_in, .cat_hi_in, .cat_sel, .opa, .opb,
    .carry_in, .add_not_sub, .mult_bit, .ram_wr_en, .ram_wr_data,
    .nb_wr_en, .nb_wr_addr, .nb_wr_data, .func0(), .func1(), .func5(),
    .cat_out(), .carry_out(), .carry_gen(), .carry_prop(),
    .ram_rd_data(red_rd_data), .wr_bus_en(), .wr_bus_addr(),
    .wr_bus_data(), .result_q(), .carry_q(), .cmp_q(),
    .mode_err_q(red_err_q));
  cls_nb_model #(.LO_TBL(NB_LO), .HI_TBL(NB_HI)) nb (.nb_addr, .cat_lo_in,
    .cat_hi_in);

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic load(logic sel, logic [15:0] v);
    cfg_load = 1'h1;
    cfg_load_sel = sel;
    cfg_contents = v;
    tick(1);
    cfg_load = 1'h0;
  endtask

  // Count must start from the reset value, so this runs first
  task automatic t_count();
    logic [1:0] e;
    cfg_mode = CLS_MODE_RIPPLE;
    cfg_op = CLS_OP_UP;
    carry_in = 1'h1;
    for (int i = 1; i < 9; i++) begin
      if (i == 5) cfg_op = CLS_OP_DOWN;
      if (i == 5) carry_in = 1'h0;
      e = i < 5 ? i[1:0] : -i[1:0];
      tick(1);
      check("count", result_q, e);
    end
    // Clock enable low must freeze the counter and its result
    clk_en = 1'h0;
    tick(2);
    check("frozen", result_q, 2'h0);
    clk_en = 1'h1;
    tick(1);
    check("resumed", result_q, 2'h3);
  endtask
  // Same walk serves programmed logic and fixed contents
  task automatic t_logic(cls_mode_type m);
    cfg_mode = m;
    cfg_five_input = (m == CLS_MODE_ROM);
    load(1'h0, P0);
    load(1'h1, P1);
    for (int i = 0; i < 16; i++) begin
      tbl0_in = i[3:0];
      tbl1_in = 4'hF - i[3:0];
      fifth_in = i[0];
      #1;
      check("func0", func0, P0[i]);
      check("func1", func1, P1[15-i]);
      check("func5", func5, i[0] ? P1[15-i] : P0[i]);
      tick(1);
    end
  endtask
  task automatic t_cat();
    for (int i = 0; i < 32; i++) begin
      nb_addr = i[3:0];
      cat_sel = i[4];
      #1;
      check("cat_out", cat_out, i[4] ? NB_HI[i[3:0]] : NB_LO[i[3:0]]);
      tick(1);
    end
  endtask
  task automatic t_arith();
    logic [2:0] s;
    logic [1:0] b;
    cfg_mode = CLS_MODE_RIPPLE;
    foreach (ops[k]) for (int i = 0; i < 64; i++) begin
      cfg_op = ops[k];
      {add_not_sub, carry_in, opb, opa} = i[5:0];
      mult_bit = add_not_sub;
      b = opb;
      if (k == 1 || k == 2 && !i[5]) b = ~opb;
      if (k == 3) b = opb & {2{mult_bit}};
      s = opa + b + carry_in;
      tick(1);
      check("result_q", result_q, s[1:0]);
      check("carry_q", carry_q, s[2]);
    end
  endtask
  task automatic t_cmp();
    logic e;
    cfg_op = CLS_OP_CMP;
    for (int i = 0; i < 48; i++) begin
      cfg_cmp = cls_cmp_type'(i[5:4]);
      {opb, opa} = i[3:0];
      e = i[5:4] == 0 ? opa >= opb : i[5:4] == 1 ? opa != opb : opa <= opb;
      tick(1);
      check("cmp_q", cmp_q, e);
    end
  endtask
  task automatic t_fast();
    cfg_op = CLS_OP_ADD;
    cfg_fast_carry = 1'h1;
    for (int i = 0; i < 32; i++) begin
      {carry_in, opb, opa} = i[4:0];
      #1;
      check("carry_gen", carry_gen, opa + opb > 3);
      check("carry_prop", carry_prop, &(opa ^ opb));
      check("carry_out", carry_out, opa + opb + carry_in > 3);
      tick(1);
    end
    cfg_fast_carry = 1'h0;
  endtask
  // Back-to-back writes, read back, then the companion port
  task automatic t_ram();
    cfg_mode = CLS_MODE_RAM;
    ram_wr_en = 1'h1;
    for (int i = 0; i < 16; i++) begin
      tbl0_in = i[3:0];
      ram_wr_data = i[1:0] ^ i[3:2];
      tick(1);
    end
    ram_wr_en = 1'h0;
    for (int i = 0; i < 16; i++) begin
      tbl0_in = i[3:0];
      #1;
      check("ram_rd_data", ram_rd_data, i[1:0] ^ i[3:2]);
      check("red_rd_data", red_rd_data, 2'h0);
      tick(1);
    end
    check("mode_err_q", mode_err_q, 1'h0);
    check("red_err_q", red_err_q, 1'h1);
    cfg_ram_role = CLS_RAM_RW_PORT;
    ram_wr_en = 1'h1;
    ram_wr_data = 2'h3;
    #1;
    check("wr_bus", {wr_bus_en, wr_bus_data, wr_bus_addr}, 7'h7F);
    tick(1);
    {ram_wr_en, nb_wr_en, nb_wr_addr, nb_wr_data} = 8'h49;
    cfg_ram_role = CLS_RAM_RO_PORT;
    tbl0_in = 4'h2;
    tick(1);
    nb_wr_en = 1'h0;
    check("ro_read", ram_rd_data, 2'h1);
    cfg_mode = CLS_MODE_LOGIC;
    cfg_ram_role = CLS_RAM_SINGLE;
    ram_wr_en = 1'h1;
    tick(1);
    ram_wr_en = 1'h0;
    check("ram_off", ram_rd_data, 2'h0);
    cfg_mode = CLS_MODE_RAM;
    #1;
    check("refused_wr", ram_rd_data, 2'h1);
  endtask

  // Main sequence after ten cycles of reset
  initial begin
    tick(10);
    sys_rst = 1'h0;
    t_count();
    t_logic(CLS_MODE_LOGIC);
    t_logic(CLS_MODE_ROM);
    t_cat();
    t_arith();
    t_cmp();
    t_fast();
    t_ram();
    report_and_stop();
  end
  // Hang guard, well above the roughly 500 cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
endmodule
